/* tmz_pkg.sv */
package tmz_pkg;
    // register byte offsets on the apb slave
    localparam logic [7:0] ADDR_COUNT_LOW = 8'h00;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'h04;
    localparam logic [7:0] ADDR_CONTROL_PRIMARY = 8'h08;
    localparam logic [7:0] ADDR_CONTROL_CLOCKING = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

    // field positions inside timer_control_primary
    localparam int CP_ENABLE_BIT = 7;
    localparam int CP_OUT_STATUS_BIT = 5;
    localparam int CP_WIDTH_BIT = 4;
    // field positions inside timer_control_clocking
    localparam int CC_SOURCE_LSB = 5;
    localparam int CC_ASYNC_BIT = 4;

    // values after reset
    localparam logic [7:0] RESET_COUNT_LOW = 8'h00;
    localparam logic [7:0] RESET_COUNT_HIGH = 8'h00;
    localparam logic [7:0] RESET_CONTROL_PRIMARY = 8'h00;
    localparam logic [7:0] RESET_CONTROL_CLOCKING = 8'h00;

    // prescaler chain length: ratio 2^15 needs 15 stages
    localparam int PRESCALE_BITS = 15;

    typedef enum logic [2:0] {
        TMZ_SRC_PIN_TRUE = 3'h0,
        TMZ_SRC_PIN_INVERTED = 3'h1,
        TMZ_SRC_SYSCLK_DIV4 = 3'h2,
        TMZ_SRC_HF_OSC = 3'h3,
        TMZ_SRC_LF_OSC = 3'h4,
        TMZ_SRC_SECONDARY_OSC = 3'h5,
        TMZ_SRC_LOGIC_CELL_ONE = 3'h6,
        TMZ_SRC_RESERVED = 3'h7
    } tmz_src_t;

    // apb request as seen by the slave
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } tmz_apb_req_t;

    // count clock sources arriving from outside the block
    typedef struct packed {
        logic count_input_pin;
        logic high_freq_internal_osc;
        logic low_freq_internal_osc;
        logic secondary_oscillator;
        logic logic_cell_one_output;
    } tmz_clk_src_t;
endpackage

/* tmz_src_model.sv */
`timescale 1ns/1ps
module tmz_src_model
    import tmz_pkg::*;
(
    input wire logic clk,
    input wire logic [2:0] sel,
    output tmz_clk_src_t src
);
    logic lvl = 1'b0;
    // only the selected line moves, the logic cell line for codes 2 and 7 too; the inverted pin idles high
    always_comb begin
        src = '0;
        case (sel)
            3'h0: src.count_input_pin = lvl;
            3'h1: src.count_input_pin = ~lvl;
            3'h3: src.high_freq_internal_osc = lvl;
            3'h4: src.low_freq_internal_osc = lvl;
            3'h5: src.secondary_oscillator = lvl;
            default: src.logic_cell_one_output = lvl;
        endcase
    end
    // three clocks high, four low before the next pulse: above the two-clock minimum for sync mode
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge clk) lvl <= 1'b1;
            repeat (3) @(posedge clk);
            lvl <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask
endmodule

/* tmz_sync2.sv */
`timescale 1ns/1ps
module tmz_sync2 (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic d,
    output logic q
);
    typedef struct packed {
        logic s1;
        logic s2;
    } tmz_sync_st_t;

    tmz_sync_st_t r;
    tmz_sync_st_t next_r;

    // first stage is only ever read by the second
    always_comb begin
        next_r = r;
        next_r.s1 = d;
        next_r.s2 = r.s1;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign q = r.s2;
endmodule

/* tmz_timer.sv */
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
// Function
// - the output divider field divides match or rollover events by its value plus one, 1:1 up to 1:16.
// - the clock source field picks pin true, pin inverted, sysclk/4, hf osc, lf osc, secondary osc, logic cell one; 111 gives no clock.
// - with the async bit set the prescaled input reaches the counter without the synchroniser.
// - the high and low bytes of the 16-bit count are separate software byte registers.
// - an event occurs when low equals high in 8-bit mode or when the 16-bit count rolls over from ffff.
// - the event flag is set once per divider value plus one events, every event at 1:1.
// - the width bit selects a 16-bit counter when 1 and an 8-bit counter compared against high when 0.
// - the enable bit runs the timer when 1 and holds it idle when 0.
module tmz_timer (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire tmz_pkg::tmz_apb_req_t apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire tmz_pkg::tmz_clk_src_t clk_src,
    output logic timer_out,
    output logic irq
);
    import tmz_pkg::*;

    typedef struct packed {
        logic src_q;
        logic [1:0] div4;
        logic [PRESCALE_BITS-1:0] pre_cnt;
        logic lvl_q;
        logic [7:0] count_low_byte;
        logic [7:0] count_high_byte;
        logic timer_module_enable;
        logic width_select;
        logic [3:0] output_divider_select;
        logic [3:0] post_cnt;
        logic timer_output_status;
        tmz_src_t count_clock_source_select;
        logic input_async_select;
        logic [3:0] input_prescale_select;
        logic irq_status;
        logic irq_mask;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
    } tmz_state_t;

    tmz_state_t r;
    tmz_state_t next_r;
    logic sync_lvl;
    logic pre_lvl;

    // prescaled level picked for the synchroniser; stage chosen by the prescale field
    always_comb begin
        if (r.input_prescale_select == 4'h0) begin
            pre_lvl = r.src_q;
        end else begin
            pre_lvl = r.pre_cnt[r.input_prescale_select - 4'h1];
        end
    end

    tmz_sync2 u_sync (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .d(pre_lvl),
        .q(sync_lvl)
    );

    // whole timer, register file and bus answer
    always_comb begin
        logic sel;
        logic cnt_lvl;
        logic tick;
        logic evt;
        logic flag_set;
        logic setup;
        logic access;
        logic wr;
        logic rd_status;
        logic clr_scalers;
        logic hit;
        logic [15:0] wide_next;
        sel = 1'b0;
        cnt_lvl = 1'b0;
        tick = 1'b0;
        evt = 1'b0;
        flag_set = 1'b0;
        hit = 1'b0;
        setup = 1'b0;
        access = 1'b0;
        wr = 1'b0;
        rd_status = 1'b0;
        clr_scalers = 1'b0;
        wide_next = 16'h0000;
        next_r = r;

        // count source mux; reserved code gives a dead input
        unique case (r.count_clock_source_select)
            TMZ_SRC_PIN_TRUE: sel = clk_src.count_input_pin;
            TMZ_SRC_PIN_INVERTED: sel = ~clk_src.count_input_pin;
            TMZ_SRC_SYSCLK_DIV4: sel = r.div4[1];
            TMZ_SRC_HF_OSC: sel = clk_src.high_freq_internal_osc;
            TMZ_SRC_LF_OSC: sel = clk_src.low_freq_internal_osc;
            TMZ_SRC_SECONDARY_OSC: sel = clk_src.secondary_oscillator;
            TMZ_SRC_LOGIC_CELL_ONE: sel = clk_src.logic_cell_one_output;
            TMZ_SRC_RESERVED: sel = 1'b0;
        endcase
        next_r.div4 = r.div4 + 2'h1;
        next_r.src_q = sel;

        // prescaler ripples on source rising edges; held clear while disabled to save toggling
        if (!r.timer_module_enable) begin
            next_r.pre_cnt = '0;
        end else if (sel && !r.src_q) begin
            next_r.pre_cnt = r.pre_cnt + 15'h0001;
        end

        // async skips two flops of latency but gives no metastability margin
        cnt_lvl = r.input_async_select ? pre_lvl : sync_lvl;
        next_r.lvl_q = cnt_lvl;
        tick = r.timer_module_enable && cnt_lvl && !r.lvl_q;

        // counter in 8-bit compare or 16-bit rollover form
        if (tick) begin
            if (r.width_select) begin
                wide_next = {r.count_high_byte, r.count_low_byte} + 16'h0001;
                next_r.count_high_byte = wide_next[15:8];
                next_r.count_low_byte = wide_next[7:0];
                evt = ({r.count_high_byte, r.count_low_byte} == 16'hffff);
            end else begin
                hit = (r.count_low_byte == r.count_high_byte);
                next_r.count_low_byte = hit ? 8'h00 : r.count_low_byte + 8'h01;
                evt = hit;
            end
        end

        // postscaler: one flag per divider+1 events, output toggles with it
        if (evt) begin
            if (r.post_cnt == r.output_divider_select) begin
                next_r.post_cnt = 4'h0;
                flag_set = 1'b1;
                next_r.timer_output_status = ~r.timer_output_status;
            end else begin
                next_r.post_cnt = r.post_cnt + 4'h1;
            end
        end

        // apb slave: answer prepared in setup, taken in the first access cycle
        setup = apb_req.psel && !apb_req.penable;
        access = apb_req.psel && apb_req.penable && r.pready;
        wr = access && apb_req.pwrite;
        rd_status = access && !apb_req.pwrite && (apb_req.paddr == ADDR_IRQ_STATUS);
        next_r.pready = setup;
        next_r.pslverr = 1'b0;
        if (setup) begin
            next_r.prdata = 32'h0000_0000;
            unique case (apb_req.paddr)
                ADDR_COUNT_LOW: next_r.prdata[7:0] = r.count_low_byte;
                ADDR_COUNT_HIGH: next_r.prdata[7:0] = r.count_high_byte;
                ADDR_CONTROL_PRIMARY: begin
                    next_r.prdata[CP_ENABLE_BIT] = r.timer_module_enable;
                    next_r.prdata[CP_OUT_STATUS_BIT] = r.timer_output_status;
                    next_r.prdata[CP_WIDTH_BIT] = r.width_select;
                    next_r.prdata[3:0] = r.output_divider_select;
                end
                ADDR_CONTROL_CLOCKING: begin
                    next_r.prdata[CC_SOURCE_LSB+2:CC_SOURCE_LSB] = r.count_clock_source_select;
                    next_r.prdata[CC_ASYNC_BIT] = r.input_async_select;
                    next_r.prdata[3:0] = r.input_prescale_select;
                end
                ADDR_IRQ_STATUS: next_r.prdata[0] = r.irq_status || flag_set; // an event now is shown, not lost
                ADDR_IRQ_MASK: next_r.prdata[0] = r.irq_mask;
                default: next_r.pslverr = 1'b1; // unmapped reads zero with an error
            endcase
        end

        // software writes win over the counter update of the same cycle
        if (wr) begin
            unique case (apb_req.paddr)
                ADDR_COUNT_LOW: begin
                    next_r.count_low_byte = apb_req.pwdata[7:0];
                    clr_scalers = 1'b1;
                end
                ADDR_COUNT_HIGH: next_r.count_high_byte = apb_req.pwdata[7:0];
                ADDR_CONTROL_PRIMARY: begin
                    next_r.timer_module_enable = apb_req.pwdata[CP_ENABLE_BIT];
                    next_r.width_select = apb_req.pwdata[CP_WIDTH_BIT];
                    next_r.output_divider_select = apb_req.pwdata[3:0];
                    clr_scalers = 1'b1;
                end
                ADDR_CONTROL_CLOCKING: begin
                    next_r.count_clock_source_select = tmz_src_t'(apb_req.pwdata[CC_SOURCE_LSB+2:CC_SOURCE_LSB]);
                    next_r.input_async_select = apb_req.pwdata[CC_ASYNC_BIT];
                    next_r.input_prescale_select = apb_req.pwdata[3:0];
                end
                ADDR_IRQ_MASK: next_r.irq_mask = apb_req.pwdata[0];
                default: ;
            endcase
        end
        if (clr_scalers) begin
            next_r.pre_cnt = '0;
            next_r.post_cnt = 4'h0;
        end

        // sticky flag: a new event beats the read-clear of the same cycle
        next_r.irq_status = (r.irq_status && !rd_status) || flag_set;
        next_r.irq = next_r.irq_status && next_r.irq_mask;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
            r.count_low_byte <= RESET_COUNT_LOW;
            r.count_high_byte <= RESET_COUNT_HIGH;
            r.timer_module_enable <= RESET_CONTROL_PRIMARY[CP_ENABLE_BIT];
            r.count_clock_source_select <= tmz_src_t'(RESET_CONTROL_CLOCKING[CC_SOURCE_LSB+2:CC_SOURCE_LSB]);
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign timer_out = r.timer_output_status;
    assign irq = r.irq;
endmodule

/* tmz_timer_sva.sv */
`timescale 1ns/1ps
module tmz_timer_sva
    import tmz_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire tmz_apb_req_t apb_req,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire tmz_clk_src_t clk_src,
    input wire logic timer_out,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    logic acc;
    logic mapped;
    logic mask_q;
    // access edge and decode, as seen from the pins
    assign acc = pready && apb_req.psel && apb_req.penable;
    assign mapped = apb_req.paddr inside {ADDR_COUNT_LOW, ADDR_COUNT_HIGH, ADDR_CONTROL_PRIMARY,
        ADDR_CONTROL_CLOCKING, ADDR_IRQ_STATUS, ADDR_IRQ_MASK};
    // mirror of the mask bit, the checker cannot look inside
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mask_q <= 1'b0;
        end else if (ce && acc && apb_req.pwrite && apb_req.paddr == ADDR_IRQ_MASK) begin
            mask_q <= apb_req.pwdata[0];
        end
    end
    sequence s_setup;
        apb_req.psel && !apb_req.penable && ce;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    a_ready_once: assert property (s_setup |=> s_answer) else $error("pready not one cycle after setup");
    a_err_unmapped: assert property (acc && !mapped |-> pslverr) else $error("no error on unmapped");
    a_ok_mapped: assert property (acc && mapped |-> !pslverr) else $error("error on mapped address");
    a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
    a_read_upper_zero: assert property (acc && !apb_req.pwrite |-> prdata[31:8] == 24'h0)
        else $error("read data above byte not zero");
    // a new event on the clearing edge wins, and it shows as an output toggle
    a_irq_read_clear: assert property (acc && !apb_req.pwrite && apb_req.paddr == ADDR_IRQ_STATUS |=>
        !irq || $changed(timer_out)) else $error("irq stays after status read");
    a_irq_follows_out: assert property (mask_q && $changed(timer_out) |-> irq)
        else $error("no irq with output toggle");
    a_irq_has_cause: assert property ($rose(irq) |-> $changed(timer_out) ||
        $past(acc && apb_req.pwrite && apb_req.paddr == ADDR_IRQ_MASK)) else $error("irq rose without cause");
endmodule
bind tmz_timer tmz_timer_sva u_sva (.clk(clk), .resetn(resetn), .ce(ce), .apb_req(apb_req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .clk_src(clk_src), .timer_out(timer_out), .irq(irq));

/* tmz_timer_test.sv */
`timescale 1ns/1ps
module tmz_timer_test;
    import tmz_pkg::*;
    logic clk;
    logic resetn;
    tmz_apb_req_t apb_req;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    tmz_clk_src_t clk_src;
    logic timer_out;
    logic irq;
    logic [2:0] sel;
    logic ce;
    logic [31:0] last_rd;
    int fail_count;
    int comparisons;
    tmz_timer u_tmz_timer (.clk(clk), .resetn(resetn), .ce(ce), .apb_req(apb_req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .clk_src(clk_src), .timer_out(timer_out), .irq(irq));
    tmz_src_model u_tmz_src_model (.clk(clk), .sel(sel), .src(clk_src));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, seen);
            fail_count++;
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // one transfer; the request stands until pready is sampled high, read data kept in last_rd
    // unmapped addresses answer with an error for reads and writes alike
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        apb_req <= '{1'b1, 1'b0, w, a, wd};
        @(posedge clk);
        apb_req.penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        last_rd = prdata;
        chk("pslverr", {31'h0, pslverr}, {31'h0, !(a inside {ADDR_COUNT_LOW, ADDR_COUNT_HIGH,
            ADDR_CONTROL_PRIMARY, ADDR_CONTROL_CLOCKING, ADDR_IRQ_STATUS, ADDR_IRQ_MASK})});
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk($sformatf("rd %h", a), last_rd, exp);
    endtask
    // pulses then room for the two-flop synchroniser and edge detect
    task automatic drive(input int n);
        u_tmz_src_model.pulse(n);
        repeat (6) @(posedge clk);
    endtask
    task automatic t_reset();
        rd(ADDR_COUNT_LOW, 32'h0);
        rd(ADDR_COUNT_HIGH, 32'h0);
        rd(ADDR_CONTROL_CLOCKING, 32'h0);
        rd(8'h20, 32'h0);
        wr(8'h20, 32'hff);
        wr(ADDR_CONTROL_PRIMARY, 32'h6f);
        rd(ADDR_CONTROL_PRIMARY, 32'h0f);
    endtask
    // each source but sysclk/4 counts its own line; the reserved code counts nothing
    task automatic t_sources();
        logic [2:0] codes[7] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
        wr(ADDR_CONTROL_PRIMARY, 32'h90);
        foreach (codes[i]) begin
            sel <= codes[i];
            wr(ADDR_CONTROL_CLOCKING, {24'h0, codes[i], codes[i][0], 4'h0});
            wr(ADDR_COUNT_LOW, 32'h0);
            drive(3);
            rd(ADDR_COUNT_LOW, (codes[i] == 3'h7) ? 32'h0 : 32'h3);
        end
        sel <= 3'h0;
        wr(ADDR_CONTROL_CLOCKING, 32'h02);
        wr(ADDR_COUNT_LOW, 32'h0);
        drive(9);
        rd(ADDR_COUNT_LOW, 32'h2);
    endtask
    // compare at zero makes every tick an event; the flag needs divider plus one
    task automatic t_post();
        logic [3:0] divs[2] = '{4'h0, 4'hf};
        wr(ADDR_CONTROL_CLOCKING, 32'h0);
        wr(ADDR_COUNT_HIGH, 32'h0);
        wr(ADDR_IRQ_MASK, 32'h1);
        foreach (divs[i]) begin
            wr(ADDR_COUNT_LOW, 32'h0);
            wr(ADDR_CONTROL_PRIMARY, {24'h0, 4'h8, divs[i]});
            drive(divs[i]);
            chk("irq", {31'h0, irq}, 32'h0);
            drive(1);
            chk("timer_out", {31'h0, timer_out}, {31'h0, ~i[0]});
            chk("irq", {31'h0, irq}, 32'h1);
            rd(ADDR_IRQ_STATUS, 32'h1);
            rd(ADDR_IRQ_STATUS, 32'h0);
            chk("irq", {31'h0, irq}, 32'h0);
        end
    endtask
    // rollover from ffff, then a disabled timer holds its count
    task automatic t_roll();
        wr(ADDR_CONTROL_PRIMARY, 32'h90);
        wr(ADDR_COUNT_HIGH, 32'hff);
        wr(ADDR_COUNT_LOW, 32'hfe);
        drive(1);
        rd(ADDR_IRQ_STATUS, 32'h0);
        drive(1);
        rd(ADDR_IRQ_STATUS, 32'h1);
        rd(ADDR_COUNT_HIGH, 32'h0);
        wr(ADDR_CONTROL_PRIMARY, 32'h10);
        drive(2);
        rd(ADDR_COUNT_LOW, 32'h0);
    endtask
    // system clock over four runs free; 44 cycles between two snapshots hold exactly 11 ticks
    task automatic t_div4();
        logic [31:0] first;
        wr(ADDR_CONTROL_PRIMARY, 32'h90);
        wr(ADDR_CONTROL_CLOCKING, 32'h40);
        // let the switch-over edge pass so the window sees only the steady divider
        repeat (8) @(posedge clk);
        apb(1'b0, ADDR_COUNT_LOW, 32'h0);
        first = last_rd;
        repeat (41) @(posedge clk);
        apb(1'b0, ADDR_COUNT_LOW, 32'h0);
        chk("div4 ticks", last_rd - first, 32'h0000000b);
    endtask
    // clock enable low freezes source sampling, synchroniser and counter alike
    task automatic t_freeze();
        wr(ADDR_CONTROL_CLOCKING, 32'h0);
        repeat (8) @(posedge clk);
        wr(ADDR_COUNT_LOW, 32'h0);
        ce <= 1'b0;
        drive(2);
        ce <= 1'b1;
        rd(ADDR_COUNT_LOW, 32'h0);
        drive(1);
        rd(ADDR_COUNT_LOW, 32'h1);
    endtask
    initial begin
        apb_req = '0;
        sel = 3'h0;
        ce = 1'b1;
        last_rd = 32'h0;
        fail_count = 0;
        comparisons = 0;
        resetn = 1'b0;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_sources();
        t_post();
        t_roll();
        t_div4();
        t_freeze();
        give_verdict();
    end
    // the whole run needs some 730 cycles
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        give_verdict();
    end
endmodule
